// file: design/cmsr_regs.sv
// core register file mirrored into every data memory bank
// assumes the execution logic on the same clock drives all inputs
//
// Notes on behaviour
// RULE1: port zero redirects through pointer zero
// RULE2: port one redirects through pointer one
// RULE3: core registers mirror at every bank
// RULE4: program counter low byte readable, writable, zeroed
// RULE5: timeout flag set by clear/sleep, cleared on timeout
// RULE6: power-down flag set by clear, cleared by sleep
// RULE7: zero flag follows an all-zero result
// RULE8: nibble flag is carry out of bit three
// RULE9: carry flag is carry out of bit seven
// RULE10: subtract adds complement; carry means no borrow
// RULE11: rotates load carry with the shifted-out bit
// RULE12: timeout, power-down read-only; cold reset sets both
// RULE13: arithmetic flags writable; only cold reset clears them
// RULE14: pointer zero is sixteen bits, two bytes, zeroed
// RULE15: pointer one is sixteen bits, two bytes, zeroed
// RULE16: bank select supplies top six direct address bits
// RULE17: memory reachable directly and through both pointers
// RULE18: accumulator eight bits, mirrored, reset to zero
// RULE19: pointer bit fifteen reads flash low byte, slower
// RULE20: eeprom window read-only, one extra cycle
// RULE21: linear window maps onto the ram blocks of banks 0 to 50
// RULE22: unimplemented locations read as zero
// RULE23: unused status and bank bits read zero
`timescale 1ns/1ps
`default_nettype none
module cmsr_regs
  import cmsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic coldReset,
  input wire logic causeTimeout,
  input wire logic causePowerDown,
  input wire cmsr_mem_req_t memReq,
  output logic memBusy,
  output logic memDone,
  output logic [7:0] memRdata,
  output cmsr_ext_req_t extReq,
  input wire logic [7:0] extRdata,
  input wire logic extHit,
  output cmsr_nvm_req_t nvmReq,
  input wire logic [7:0] nvmRdata,
  input wire cmsr_alu_in_t aluIn,
  output logic [7:0] aluResult,
  input wire logic watchdogClear,
  input wire logic sleepExec,
  input wire logic watchdogTimeout,
  input wire logic pcAdvance,
  input wire logic [7:0] pcLowIn,
  output logic [7:0] pcLow,
  output logic pcLowWritten,
  output cmsr_flags_t statusFlags,
  output logic [15:0] ptr0Addr,
  output logic [15:0] ptr1Addr,
  output logic [5:0] bankSel,
  output logic [7:0] accOut
);

  cmsr_state_t st_ff;
  cmsr_state_t nxt_st;
  cmsr_state_t rstVal;
  logic accept;
  logic indirect;
  logic [15:0] effAddr;
  cmsr_region_t region;
  logic [7:0] aluRes;
  logic aluZero;
  logic aluNibble;
  logic aluCarry;
  logic updZero;
  logic updNibble;
  logic updCarry;

  cmsr_alu u_alu (
    .op(aluIn.op),
    .a(aluIn.a),
    .b(aluIn.b),
    .carryIn(st_ff.flags.carry),
    .result(aluRes),
    .zeroOut(aluZero),
    .nibbleOut(aluNibble),
    .carryOut(aluCarry),
    .updZero(updZero),
    .updNibble(updNibble),
    .updCarry(updCarry)
  );

  function automatic cmsr_region_t regionOf(input logic [15:0] a);
    if (a[FLASH_BIT])
    begin
      regionOf = RG_FLASH; // RULE19
    end
    else if (a <= TRAD_TOP)
    begin
      // a pointer aimed at a port itself has nothing behind it
      if (a[6:0] <= OFF_PORT1)
        regionOf = RG_NEST;
      else if (a[6:0] <= OFF_ACC)
        regionOf = RG_CORE; // RULE3
      else
        regionOf = RG_EXT;
    end
    else if (a >= LIN_BASE && a <= LIN_TOP)
      regionOf = RG_EXT; // RULE21
    else if (a >= EE_BASE && a <= EE_TOP)
      regionOf = RG_EE; // RULE20
    else
      regionOf = RG_NONE; // RULE22
  endfunction : regionOf

  // divider by the block size is costly but only spans twelve bits
  function automatic logic [12:0] mapExt(input logic [15:0] a);
    logic [11:0] bnk;
    logic [11:0] idx;
    bnk = a[11:0] / LIN_RAM_SIZE;
    idx = a[11:0] % LIN_RAM_SIZE;
    if (a <= TRAD_TOP)
      mapExt = a[12:0];
    else
      mapExt = {bnk[5:0], OFF_RAM_BASE + idx[6:0]}; // RULE21
  endfunction : mapExt

  function automatic logic [7:0] readCore(input logic [6:0] off,
                                          input cmsr_state_t s);
    unique case (off)
      OFF_PC_LOW: readCore = s.pcLow; // RULE4
      OFF_STATUS: readCore = statusByte(s.flags); // RULE23
      OFF_PTR0_LO: readCore = s.pointer0[7:0]; // RULE14
      OFF_PTR0_HI: readCore = s.pointer0[15:8]; // RULE14
      OFF_PTR1_LO: readCore = s.pointer1[7:0]; // RULE15
      OFF_PTR1_HI: readCore = s.pointer1[15:8]; // RULE15
      OFF_BANK: readCore = {2'h0, s.bank}; // RULE23
      OFF_ACC: readCore = s.acc; // RULE18
      default: readCore = UNIMPL_READ;
    endcase
  endfunction : readCore

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.pcLowWritten = 1'b0;
    nxt_st.ext.req = 1'b0;
    nxt_st.nvm.req = 1'b0;
    accept = memReq.valid && (st_ff.fsm == ST_IDLE);
    indirect = (memReq.addr == OFF_PORT0) || (memReq.addr == OFF_PORT1);
    if (memReq.addr == OFF_PORT0)
      effAddr = st_ff.pointer0; // RULE1
    else if (memReq.addr == OFF_PORT1)
      effAddr = st_ff.pointer1; // RULE2
    else
      effAddr = {3'h0, st_ff.bank, memReq.addr}; // RULE16 RULE17
    region = regionOf(effAddr);

    // the core may advance the counter; a software write overrides it
    if (pcAdvance)
      nxt_st.pcLow = pcLowIn; // RULE4

    unique case (st_ff.fsm)
      ST_IDLE:
      begin
        if (accept)
        begin
          nxt_st.pendWr = memReq.wr;
          nxt_st.pendNvm = 1'b0;
          unique case (region)
            RG_CORE:
            begin
              nxt_st.done = 1'b1;
              if (!memReq.wr)
                nxt_st.rdata = readCore(effAddr[6:0], st_ff); // RULE3
              else
              begin
                unique case (effAddr[6:0])
                  OFF_PC_LOW:
                  begin
                    nxt_st.pcLow = memReq.wdata; // RULE4
                    nxt_st.pcLowWritten = 1'b1;
                  end
                  OFF_STATUS:
                  begin
                    // timeout and power-down ignore software
                    nxt_st.flags.zero = memReq.wdata[STAT_ZERO]; // RULE13
                    nxt_st.flags.nibble = memReq.wdata[STAT_NIBBLE]; // RULE13
                    nxt_st.flags.carry = memReq.wdata[STAT_CARRY]; // RULE13
                  end
                  OFF_PTR0_LO: nxt_st.pointer0[7:0] = memReq.wdata; // RULE14
                  OFF_PTR0_HI: nxt_st.pointer0[15:8] = memReq.wdata; // RULE14
                  OFF_PTR1_LO: nxt_st.pointer1[7:0] = memReq.wdata; // RULE15
                  OFF_PTR1_HI: nxt_st.pointer1[15:8] = memReq.wdata; // RULE15
                  OFF_BANK: nxt_st.bank = memReq.wdata[5:0]; // RULE16
                  OFF_ACC: nxt_st.acc = memReq.wdata; // RULE18
                  default: nxt_st.acc = st_ff.acc;
                endcase
              end
            end
            RG_EXT:
            begin
              nxt_st.ext.req = 1'b1; // RULE17
              nxt_st.ext.wr = memReq.wr;
              nxt_st.ext.addr = mapExt(effAddr); // RULE1 RULE2 RULE21
              nxt_st.ext.wdata = memReq.wdata;
              nxt_st.fsm = ST_ISSUE;
            end
            RG_EE, RG_FLASH:
            begin
              if (memReq.wr)
                nxt_st.done = 1'b1; // RULE19 RULE20
              else
              begin
                nxt_st.nvm.req = 1'b1;
                nxt_st.nvm.eeprom = (region == RG_EE); // RULE20
                nxt_st.nvm.addr = (region == RG_EE) ?
                  {7'h00, effAddr[7:0]} : effAddr[14:0]; // RULE19
                nxt_st.pendNvm = 1'b1;
                nxt_st.fsm = ST_ISSUE;
              end
            end
            RG_NEST, RG_NONE:
            begin
              nxt_st.done = 1'b1;
              nxt_st.rdata = UNIMPL_READ; // RULE22
            end
          endcase
        end
      end
      ST_ISSUE:
      begin
        if (st_ff.pendWr)
        begin
          nxt_st.done = 1'b1;
          nxt_st.fsm = ST_IDLE;
        end
        else
          nxt_st.fsm = ST_CAPTURE;
      end
      ST_CAPTURE:
      begin
        if (st_ff.pendNvm)
        begin
          nxt_st.rdata = nvmRdata;
          nxt_st.fsm = ST_EXTRA; // RULE19 RULE20
        end
        else
        begin
          nxt_st.rdata = extHit ? extRdata : UNIMPL_READ; // RULE22
          nxt_st.done = 1'b1;
          nxt_st.fsm = ST_IDLE;
        end
      end
      ST_EXTRA:
      begin
        nxt_st.done = 1'b1;
        nxt_st.fsm = ST_IDLE;
      end
    endcase
    nxt_st.busy = (nxt_st.fsm != ST_IDLE);

    // an instruction's own flag results beat a software status write
    if (aluIn.valid)
    begin
      nxt_st.aluResult = aluRes;
      if (updZero)
        nxt_st.flags.zero = aluZero; // RULE7
      if (updNibble)
        nxt_st.flags.nibble = aluNibble; // RULE8
      if (updCarry)
        nxt_st.flags.carry = aluCarry; // RULE9 RULE11
    end
    if (watchdogTimeout)
      nxt_st.flags.timeout = 1'b0; // RULE5
    if (watchdogClear)
    begin
      nxt_st.flags.timeout = 1'b1; // RULE5
      nxt_st.flags.powerDown = 1'b1; // RULE6
    end
    if (sleepExec)
    begin
      nxt_st.flags.timeout = 1'b1; // RULE5
      nxt_st.flags.powerDown = 1'b0; // RULE6
    end

    rstVal = '0;
    rstVal.fsm = ST_IDLE;
    rstVal.pointer0 = PTR_RST; // RULE14
    rstVal.pointer1 = PTR_RST; // RULE15
    rstVal.bank = BANK_RST; // RULE16
    rstVal.acc = ACC_RST; // RULE18
    rstVal.pcLow = PC_LOW_RST; // RULE4
    if (coldReset)
      rstVal.flags = FLAGS_COLD; // RULE12 RULE13
    else
    begin
      // warm reset keeps arithmetic flags, takes cause bits
      rstVal.flags = st_ff.flags; // RULE13
      rstVal.flags.timeout = causeTimeout; // RULE12
      rstVal.flags.powerDown = causePowerDown; // RULE12
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      st_ff <= rstVal;
    else if (clkEn)
      st_ff <= nxt_st;
  end

  assign memBusy = st_ff.busy;
  assign memDone = st_ff.done;
  assign memRdata = st_ff.rdata;
  assign extReq = st_ff.ext;
  assign nvmReq = st_ff.nvm;
  assign aluResult = st_ff.aluResult;
  assign pcLow = st_ff.pcLow;
  assign pcLowWritten = st_ff.pcLowWritten;
  assign statusFlags = st_ff.flags;
  assign ptr0Addr = st_ff.pointer0;
  assign ptr1Addr = st_ff.pointer1;
  assign bankSel = st_ff.bank;
  assign accOut = st_ff.acc;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence extRead;
    accept && clkEn && !memReq.wr && region == RG_EXT;
  endsequence
  sequence nvmRead;
    accept && clkEn && !memReq.wr && (region == RG_EE || region == RG_FLASH);
  endsequence

  a_port0_redirect: assert property ( // RULE1
    accept && clkEn && memReq.addr == OFF_PORT0 && !ptr0Addr[FLASH_BIT]
    && ptr0Addr <= TRAD_TOP && ptr0Addr[6:0] > OFF_ACC
    |=> extReq.req && extReq.addr == $past(ptr0Addr[12:0]))
    else $error("port zero not redirected through pointer zero");
  a_port1_redirect: assert property ( // RULE2
    accept && clkEn && memReq.addr == OFF_PORT1
    && ptr1Addr <= TRAD_TOP && ptr1Addr[6:0] > OFF_ACC
    |=> extReq.req && extReq.addr == $past(ptr1Addr[12:0]))
    else $error("port one not redirected through pointer one");
  a_acc_mirror: assert property ( // RULE3
    accept && clkEn && !memReq.wr && memReq.addr == OFF_ACC
    |=> memDone && memRdata == $past(accOut))
    else $error("mirrored accumulator read wrong");
  a_pclow_write: assert property ( // RULE4
    accept && clkEn && memReq.wr && memReq.addr == OFF_PC_LOW
    |=> pcLowWritten && pcLow == $past(memReq.wdata))
    else $error("counter low byte write lost");
  a_timeout_clear: assert property ( // RULE5
    clkEn && watchdogTimeout && !watchdogClear && !sleepExec
    |=> !statusFlags.timeout)
    else $error("timeout flag not cleared");
  a_sleep_flags: assert property ( // RULE6
    clkEn && sleepExec |=> !statusFlags.powerDown && statusFlags.timeout)
    else $error("sleep flags wrong");
  a_zero_flag: assert property ( // RULE7
    clkEn && aluIn.valid && (aluIn.op == ALU_LOGIC || aluIn.op == ALU_ADD)
    |=> statusFlags.zero == (8'($past(aluIn.a) + ($past(aluIn.op) == ALU_ADD
        ? $past(aluIn.b) : 8'h00)) == 8'h00))
    else $error("zero flag disagrees with result");
  a_add_nibble: assert property ( // RULE8
    clkEn && aluIn.valid && aluIn.op == ALU_ADD
    |=> statusFlags.nibble ==
        ((5'({1'b0, $past(aluIn.a[3:0])}) + {1'b0, $past(aluIn.b[3:0])}) > 5'h0F))
    else $error("nibble carry wrong");
  a_sub_borrow: assert property ( // RULE10
    clkEn && aluIn.valid && aluIn.op == ALU_SUB
    |=> statusFlags.carry == ($past(aluIn.a) >= $past(aluIn.b)))
    else $error("subtract carry is not inverted borrow");
  a_cold_reset: assert property ( // RULE12
    $rose(rstn) && $past(coldReset)
    |-> statusFlags == FLAGS_COLD && ptr0Addr == PTR_RST && accOut == ACC_RST)
    else $error("cold reset values wrong");
  a_nvm_extra: assert property ( // RULE19
    nvmRead ##1 clkEn [*3] |-> !memDone ##1 memDone)
    else $error("nonvolatile read not one cycle slower");
  a_ext_timing: assert property ( // RULE17
    extRead ##1 clkEn [*2] |-> !memDone ##1 memDone)
    else $error("data memory read not answered on time");
  a_unimpl_zero: assert property ( // RULE22
    accept && clkEn && !memReq.wr && region == RG_NONE
    |=> memDone && memRdata == UNIMPL_READ)
    else $error("unimplemented read not zero");
  a_bank_direct: assert property ( // RULE16
    accept && clkEn && memReq.addr > OFF_ACC
    |=> extReq.req && extReq.addr == {$past(bankSel), $past(memReq.addr)})
    else $error("direct address lacks bank bits");

endmodule : cmsr_regs
`default_nettype wire

// file: design/cmsr_pkg.sv
// shared constants, enumerations and carriers of the core register file
// assumes one core clock; every user imports the whole package
package cmsr_pkg;

  // register offsets within one bank, mirrored in every bank
  localparam logic [6:0] OFF_PORT0 = 7'h00;
  localparam logic [6:0] OFF_PORT1 = 7'h01;
  localparam logic [6:0] OFF_PC_LOW = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_PTR0_LO = 7'h04;
  localparam logic [6:0] OFF_PTR0_HI = 7'h05;
  localparam logic [6:0] OFF_PTR1_LO = 7'h06;
  localparam logic [6:0] OFF_PTR1_HI = 7'h07;
  localparam logic [6:0] OFF_BANK = 7'h08;
  localparam logic [6:0] OFF_ACC = 7'h09;
  localparam logic [6:0] OFF_RAM_BASE = 7'h20;

  // pointer address space
  localparam logic [15:0] TRAD_TOP = 16'h1FFF;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_TOP = 16'h2FEF;
  localparam logic [15:0] EE_BASE = 16'h7000;
  localparam logic [15:0] EE_TOP = 16'h70FF;
  localparam logic [11:0] LIN_RAM_SIZE = 12'h050;
  localparam int FLASH_BIT = 15;

  // status field positions
  localparam int STAT_TIMEOUT = 4;
  localparam int STAT_PDOWN = 3;
  localparam int STAT_ZERO = 2;
  localparam int STAT_NIBBLE = 1;
  localparam int STAT_CARRY = 0;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [5:0] BANK_RST = 6'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] PC_LOW_RST = 8'h00;
  localparam logic [7:0] UNIMPL_READ = 8'h00;

  typedef enum logic [2:0] {ALU_LOGIC, ALU_ADD, ALU_SUB, ALU_ROTL, ALU_ROTR}
    cmsr_alu_op_t;
  typedef enum logic [2:0] {RG_CORE, RG_NEST, RG_EXT, RG_EE, RG_FLASH, RG_NONE}
    cmsr_region_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE, ST_EXTRA}
    cmsr_fsm_t;

  typedef struct packed {
    logic timeout;
    logic powerDown;
    logic zero;
    logic nibble;
    logic carry;
  } cmsr_flags_t;

  localparam cmsr_flags_t FLAGS_COLD = STATUS_RST[4:0];

  typedef struct packed {
    logic valid;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cmsr_mem_req_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [12:0] addr;
    logic [7:0] wdata;
  } cmsr_ext_req_t;

  typedef struct packed {
    logic req;
    logic eeprom;
    logic [14:0] addr;
  } cmsr_nvm_req_t;

  typedef struct packed {
    logic valid;
    cmsr_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } cmsr_alu_in_t;

  typedef struct packed {
    cmsr_fsm_t fsm;
    logic pendWr;
    logic pendNvm;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic [15:0] pointer0;
    logic [15:0] pointer1;
    logic [5:0] bank;
    logic [7:0] acc;
    logic [7:0] pcLow;
    logic pcLowWritten;
    cmsr_flags_t flags;
    logic [7:0] aluResult;
    cmsr_ext_req_t ext;
    cmsr_nvm_req_t nvm;
  } cmsr_state_t;

  function automatic logic [7:0] statusByte(input cmsr_flags_t f);
    statusByte = {3'h0, f.timeout, f.powerDown, f.zero, f.nibble, f.carry};
  endfunction : statusByte

endpackage : cmsr_pkg

// file: design/cmsr_alu.sv
// flag arithmetic for add, subtract, rotate and logic results
// assumes combinational use inside the core register file
`timescale 1ns/1ps
`default_nettype none
module cmsr_alu
  import cmsr_pkg::*;
(
  input wire cmsr_alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carryIn,
  output logic [7:0] result,
  output logic zeroOut,
  output logic nibbleOut,
  output logic carryOut,
  output logic updZero,
  output logic updNibble,
  output logic updCarry
);

  logic [7:0] opB;
  logic addCin;
  logic [8:0] sum;
  logic [4:0] low;

  always_comb
  begin
    // subtract adds the complement plus one, so carry means no borrow
    opB = (op == ALU_SUB) ? ~b : b; // RULE10
    addCin = (op == ALU_SUB); // RULE10
    sum = {1'b0, a} + {1'b0, opB} + {8'h00, addCin};
    low = {1'b0, a[3:0]} + {1'b0, opB[3:0]} + {4'h0, addCin};
    result = a;
    nibbleOut = low[4]; // RULE8
    carryOut = sum[8]; // RULE9
    updZero = 1'b1;
    updNibble = 1'b0;
    updCarry = 1'b0;
    unique case (op)
      ALU_LOGIC:
      begin
        result = a;
      end
      ALU_ADD, ALU_SUB:
      begin
        result = sum[7:0];
        updNibble = 1'b1;
        updCarry = 1'b1;
      end
      ALU_ROTL:
      begin
        result = {a[6:0], carryIn};
        carryOut = a[7]; // RULE11
        updZero = 1'b0;
        updCarry = 1'b1;
      end
      ALU_ROTR:
      begin
        result = {carryIn, a[7:1]};
        carryOut = a[0]; // RULE11
        updZero = 1'b0;
        updCarry = 1'b1;
      end
      default:
      begin
        result = a;
      end
    endcase
    zeroOut = (result == 8'h00); // RULE7
  end

endmodule : cmsr_alu
`default_nettype wire

// file: bench/cmsr_mem_model.sv
// data memory and nonvolatile memory facing the core register file
// assumes one-cycle request pulses; answer data one cycle later
`timescale 1ns/1ps
`default_nettype none
module cmsr_mem_model
  import cmsr_pkg::*;
(
  input wire logic core_clk,
  input wire cmsr_ext_req_t extReq,
  input wire cmsr_nvm_req_t nvmReq,
  output logic [7:0] extRdata,
  output logic extHit,
  output logic [7:0] nvmRdata
);
  logic [7:0] ram [0:2047];

  initial
  begin
    extRdata = 8'h00;
    extHit = 1'b0;
    nvmRdata = 8'h00;
  end

  // lines toggle outside the answer cycle so stale data never matches
  always @(posedge core_clk)
  begin
    extRdata <= ~extRdata;
    extHit <= ~extHit;
    nvmRdata <= ~nvmRdata;
    if (extReq.req)
    begin
      // only the low 2 KB exist; garbage data beyond, with no hit
      extHit <= (extReq.addr < 13'h0800);
      extRdata <= (extReq.addr < 13'h0800) ? ram[extReq.addr[10:0]] : 8'hA5;
      if (extReq.wr && extReq.addr < 13'h0800)
        ram[extReq.addr[10:0]] <= extReq.wdata;
    end
    if (nvmReq.req)
      nvmRdata <= nvmReq.addr[7:0] ^ (nvmReq.eeprom ? 8'hA5 : 8'h3C);
  end
endmodule : cmsr_mem_model
`default_nettype wire

// file: bench/cmsr_regs_bench.sv
// self-checking bench of the core register file
// assumes the memory model answers ext and nvm requests
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    nChecks++; \
    if ((got) !== (exp)) \
    begin \
      failCount++; \
      $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module cmsr_regs_bench
  import cmsr_pkg::*;
;
  logic core_clk, rstn, coldReset, causeTimeout, causePowerDown;
  logic memBusy, memDone, extHit, pcAdvance, pcLowWritten;
  logic watchdogClear, sleepExec, watchdogTimeout;
  cmsr_mem_req_t memReq;
  cmsr_ext_req_t extReq;
  cmsr_nvm_req_t nvmReq;
  cmsr_alu_in_t aluIn;
  cmsr_flags_t statusFlags;
  logic [7:0] memRdata, extRdata, nvmRdata, aluResult, pcLowIn, pcLow;
  logic [7:0] accOut, q;
  logic [15:0] ptr0Addr, ptr1Addr;
  logic [5:0] bankSel;
  int failCount, nChecks, lat;
  int cycles = 0;
  logic [7:0] wv [2:9] = '{8'h5A, 8'hE7, 8'h34, 8'h12, 8'h80, 8'h20, 8'hFF,
    8'hC3};
  logic [7:0] ev [2:9] = '{8'h5A, 8'h1F, 8'h34, 8'h12, 8'h80, 8'h20, 8'h3F,
    8'hC3};

  cmsr_regs uut (.core_clk(core_clk), .rstn(rstn), .clkEn(1'b1),
    .coldReset(coldReset), .causeTimeout(causeTimeout),
    .causePowerDown(causePowerDown), .memReq(memReq), .memBusy(memBusy),
    .memDone(memDone), .memRdata(memRdata), .extReq(extReq),
    .extRdata(extRdata), .extHit(extHit), .nvmReq(nvmReq),
    .nvmRdata(nvmRdata), .aluIn(aluIn), .aluResult(aluResult),
    .watchdogClear(watchdogClear), .sleepExec(sleepExec),
    .watchdogTimeout(watchdogTimeout), .pcAdvance(pcAdvance),
    .pcLowIn(pcLowIn), .pcLow(pcLow), .pcLowWritten(pcLowWritten),
    .statusFlags(statusFlags), .ptr0Addr(ptr0Addr), .ptr1Addr(ptr1Addr),
    .bankSel(bankSel), .accOut(accOut));

  cmsr_mem_model mem (.core_clk(core_clk), .extReq(extReq),
    .nvmReq(nvmReq), .extRdata(extRdata), .extHit(extHit),
    .nvmRdata(nvmRdata));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // whole run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failCount++;
      stop_test();
    end
  end

  task automatic doReset(input logic cold, input logic ct, input logic cp);
    @(posedge core_clk);
    rstn <= 1'b0;
    coldReset <= cold;
    causeTimeout <= ct;
    causePowerDown <= cp;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
  endtask : doReset

  // one access; lat counts cycles from the taking edge to memDone
  task automatic xfer(input logic wr, input logic [6:0] a,
    input logic [7:0] d);
    @(posedge core_clk);
    memReq <= '{1'b1, wr, a, d};
    @(posedge core_clk);
    memReq.valid <= 1'b0;
    for (lat = 1; lat < 9; lat++)
    begin
      #1;
      if (memDone === 1'b1)
        break;
      `CHK(memBusy, 1'b1)
      @(posedge core_clk);
    end
    `CHK(memBusy, 1'b0)
    q = memRdata;
  endtask : xfer

  task automatic setPtr(input logic [6:0] lo, input logic [15:0] v);
    xfer(1'b1, lo, v[7:0]);
    xfer(1'b1, lo + 7'h01, v[15:8]);
  endtask : setPtr

  task automatic alu(input cmsr_alu_op_t op, input logic [7:0] a,
    input logic [7:0] r, input logic [4:0] f, input logic [7:0] b);
    @(posedge core_clk);
    aluIn <= '{1'b1, op, a, b};
    @(posedge core_clk);
    aluIn.valid <= 1'b0;
    #1;
    `CHK({aluResult, statusFlags}, {r, f})
  endtask : alu

  // order of bits: watchdog clear, sleep, watchdog timeout
  task automatic pulse(input logic [2:0] p, input logic [4:0] f);
    @(posedge core_clk);
    {watchdogClear, sleepExec, watchdogTimeout} <= p;
    @(posedge core_clk);
    {watchdogClear, sleepExec, watchdogTimeout} <= 3'h0;
    #1;
    `CHK(statusFlags, f)
  endtask : pulse

  initial
  begin
    rstn = 1'b0;
    coldReset = 1'b1;
    causeTimeout = 1'b0;
    causePowerDown = 1'b0;
    memReq = '0;
    aluIn = '0;
    {watchdogClear, sleepExec, watchdogTimeout} = 3'h0;
    pcAdvance = 1'b0;
    pcLowIn = 8'h00;
    failCount = 0;
    nChecks = 0;
    doReset(1'b1, 1'b0, 1'b0);
    for (int i = 2; i < 10; i++)
    begin
      xfer(1'b0, 7'(i), 8'h00);
      `CHK(q, (i == 3) ? 8'h18 : 8'h00)
    end
    // bank written to 63 at offset 8, so offset 9 and the reads back land in a mirror
    for (int i = 2; i < 10; i++)
    begin
      xfer(1'b1, 7'(i), wv[i]);
      `CHK(pcLowWritten, i == 2)
    end
    for (int i = 2; i < 10; i++)
    begin
      xfer(1'b0, 7'(i), 8'h00);
      `CHK(q, ev[i])
      `CHK(lat, 1)
    end
    `CHK({ptr0Addr, ptr1Addr}, 32'h1234_2080)
    `CHK({bankSel, accOut, pcLow}, 22'h3F_C35A)
    xfer(1'b1, 7'h08, 8'h00);
    setPtr(7'h04, 16'h0012);
    xfer(1'b1, 7'h00, 8'h77);
    xfer(1'b0, 7'h12, 8'h00);
    `CHK(q, 8'h77)
    `CHK(lat, 3)
    setPtr(7'h06, 16'h0089);
    xfer(1'b0, 7'h01, 8'h00);
    `CHK(q, 8'hC3)
    setPtr(7'h06, 16'h2055);
    xfer(1'b1, 7'h01, 8'h99);
    xfer(1'b1, 7'h08, 8'h01);
    xfer(1'b0, 7'h25, 8'h00);
    `CHK(q, 8'h99)
    setPtr(7'h04, 16'h00A5);
    xfer(1'b0, 7'h00, 8'h00);
    `CHK(q, 8'h99)
    setPtr(7'h06, 16'h00A5);
    xfer(1'b0, 7'h01, 8'h00);
    `CHK(q, 8'h99)
    setPtr(7'h06, 16'h1F00);
    xfer(1'b0, 7'h01, 8'h00);
    `CHK(q, 8'h00)
    setPtr(7'h06, 16'h3000);
    xfer(1'b0, 7'h01, 8'h00);
    `CHK(q, 8'h00)
    setPtr(7'h04, 16'h7042);
    xfer(1'b1, 7'h00, 8'h00);
    xfer(1'b0, 7'h00, 8'h00);
    `CHK({q, 8'(lat)}, 16'hE704)
    setPtr(7'h06, 16'h8123);
    xfer(1'b0, 7'h01, 8'h00);
    `CHK({q, 8'(lat)}, 16'h1F04)
    alu(ALU_ADD, 8'h0F, 8'h10, 5'b11010, 8'h01);
    alu(ALU_ADD, 8'hF0, 8'h00, 5'b11101, 8'h10);
    alu(ALU_SUB, 8'h05, 8'h00, 5'b11111, 8'h05);
    alu(ALU_SUB, 8'h01, 8'hFF, 5'b11000, 8'h02);
    alu(ALU_ROTL, 8'h81, 8'h02, 5'b11001, 8'h00);
    alu(ALU_ROTR, 8'h01, 8'h80, 5'b11001, 8'h00);
    alu(ALU_LOGIC, 8'h00, 8'h00, 5'b11101, 8'h00);
    pulse(3'b001, 5'b01101);
    pulse(3'b011, 5'b10101);
    pulse(3'b100, 5'b11101);
    pulse(3'b001, 5'b01101);
    doReset(1'b0, 1'b1, 1'b0);
    #1;
    `CHK({statusFlags, accOut}, 13'b10101_0000_0000)
    doReset(1'b1, 1'b0, 1'b0);
    #1;
    `CHK(statusFlags, 5'b11000)
    @(posedge core_clk);
    pcAdvance <= 1'b1;
    pcLowIn <= 8'h3C;
    @(posedge core_clk);
    pcAdvance <= 1'b0;
    xfer(1'b0, 7'h02, 8'h00);
    `CHK(q, 8'h3C)
    stop_test();
  end
endmodule : cmsr_regs_bench
`default_nettype wire
